// *** core/mbr_pkg.sv ***
package mbr_pkg;
	// Instruction codes served by this read path
	localparam logic [7:0]  OP_DOUT   = 8'h3b;
	localparam logic [7:0]  OP_DOUT4  = 8'h3c;
	localparam logic [7:0]  OP_QOUT   = 8'h6b;
	localparam logic [7:0]  OP_QOUT4  = 8'h6c;
	localparam logic [7:0]  OP_DIO    = 8'hbb;
	localparam logic [7:0]  OP_DIO4   = 8'hbc;
	localparam logic [7:0]  OP_QIO    = 8'heb;

	// Widths and buffer geometry
	localparam int          CNT_W     = 6;
	localparam int          COL_W     = 16;
	localparam int          MEM_AW    = 12;
	localparam int          BUF_BYTES = 2176;
	localparam logic [COL_W-1:0] BUF_LAST = 16'h087f;
	localparam logic [COL_W-1:0] ADDR_ONE = 16'h0001;

	// Clock counts of the command frame
	localparam logic [CNT_W-1:0] CNT_ONE  = 6'h01;
	localparam logic [CNT_W-1:0] OP_LAST  = 6'h07;
	localparam logic [CNT_W-1:0] COL_CLKS = 6'h10;
	localparam logic [CNT_W-1:0] BYTE_GRP = 6'h08;
	localparam logic [CNT_W-1:0] DUM_BUF  = 6'h08;
	localparam logic [CNT_W-1:0] DUM_SEQ  = 6'h20;
	localparam logic [CNT_W-1:0] DUM4_BUF = 6'h18;
	localparam logic [CNT_W-1:0] DUM4_SEQ = 6'h28;

	// Lane width as a shift: 1, 2 or 4 lines
	localparam logic [1:0]  SH_1      = 2'h0;
	localparam logic [1:0]  SH_2      = 2'h1;
	localparam logic [1:0]  SH_4      = 2'h2;

	// Output enables, low means driven
	localparam logic [3:0]  OE_OFF    = 4'hf;
	localparam logic [3:0]  OE_DUAL   = 4'hc;
	localparam logic [3:0]  OE_QUAD   = 4'h0;

	// Synchroniser reset pattern: chip select idles high
	localparam logic [5:0]  SYNC_RST  = 6'h20;

	typedef enum logic [2:0] {ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA, ST_HALT, ST_IGNORE} mbr_state_t;
endpackage : mbr_pkg

// *** core/mbr_sync.sv ***
`timescale 1ns/1ps
module mbr_sync #(
	parameter int         W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         ce_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_reg;

	// Two stages; the first is seen by the second only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_reg <= RST_VAL;
			q_o      <= RST_VAL;
		end else if (ce_i) begin
			meta_reg <= d_i;
			q_o      <= meta_reg;
		end
	end
endmodule : mbr_sync

// *** core/mbr_read_path.sv ***
`timescale 1ns/1ps
// Summary of operation
// - 3Bh: single-line frame, data on two lines
// - 3Ch: dual data, four-byte-address dummy framing
// - 6Bh: single-line frame, data on four lines
// - 6Ch: quad data, four-byte-address dummy framing
// - BBh: column sampled two bits, data on two
// - BCh: dual column input, dual data out
// - EBh: column in on four, data four
// - Buffer mode starts at received column
// - Buffer end releases lines until deselect
// - Sequential mode starts at byte zero
// - Sequential mode wraps into next page
// - Protect enable refuses all quad reads
// - Single-line: column plus 8/32 dummy clocks
// - Falling-edge output, MSB first, auto increment
// - Four-byte framing: column plus 24/40 dummies
module mbr_read_path
	import mbr_pkg::*;
#(
	parameter int DUMMY_DIO = 4,
	parameter int DUMMY_QIO = 4
) (
	input  wire logic              MCLK_I,
	input  wire logic              RST_I,
	input  wire logic              CE_I,
	input  wire logic              SCK_I,
	input  wire logic              CS_N_I,
	input  wire logic [3:0]        IO_I,
	output logic      [3:0]        IO_O,
	output logic      [3:0]        IO_OE_N_O,
	input  wire logic              BUF_MODE_I,
	input  wire logic              WP_EN_I,
	input  wire logic              BUF_WE_I,
	input  wire logic [MEM_AW-1:0] BUF_WADDR_I,
	input  wire logic [7:0]        BUF_WDATA_I,
	output logic                   PAGE_ADV_O,
	output logic                   REFUSED_O
);
	logic [7:0]       mem [BUF_BYTES];
	logic [5:0]       sync_q;
	logic             sck_s, cs_n_s, sck_d_reg, sck_rise, sck_fall;
	logic [3:0]       io_s;
	mbr_state_t       state_reg, state_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next, dum_reg, dum_next;
	logic [7:0]       op_reg, op_next, op_shift, sh_reg, sh_next, rd_byte;
	logic [3:0]       rd_hi;
	logic [COL_W-1:0] col_reg, col_next, addr_reg, addr_next;
	logic [1:0]       in_sh_reg, in_sh_next, out_sh_reg, out_sh_next;
	logic             buf_reg, buf_next, quad_op, fetch_go;
	logic [3:0]       io_next, oe_n_next;
	logic             page_adv_next, refused_next;

	// Pins come from the host's domain; SCK is sampled, not used as a clock
	mbr_sync #(.W(6), .RST_VAL(SYNC_RST)) u_sync (
		.clk_i (MCLK_I),
		.rst_i (RST_I),
		.ce_i  (CE_I),
		.d_i   ({CS_N_I, SCK_I, IO_I}),
		.q_o   (sync_q)
	);
	assign cs_n_s   = sync_q[5];
	assign sck_s    = sync_q[4];
	assign io_s     = sync_q[3:0];
	assign sck_rise = sck_s & ~sck_d_reg;
	assign sck_fall = ~sck_s & sck_d_reg;

	// Page buffer, filled by the array side before any read
	always_ff @(posedge MCLK_I) begin
		if (CE_I && BUF_WE_I) begin
			mem[BUF_WADDR_I] <= BUF_WDATA_I;
		end
	end
	assign rd_byte  = mem[addr_reg[MEM_AW-1:0]];
	assign rd_hi    = rd_byte[7:4];
	assign op_shift = {op_reg[6:0], io_s[0]};
	assign quad_op  = (op_shift == OP_QOUT) || (op_shift == OP_QOUT4) || (op_shift == OP_QIO); // Avoids a loop via op_next
	assign fetch_go = (state_reg == ST_DATA) && !cs_n_s && sck_fall && (cnt_reg == '0);

	// Next lane pattern; the top group of the byte goes out first
	function automatic logic [3:0] lane_bits(input logic [7:0] b, input logic [1:0] sh);
		lane_bits = (sh == SH_2) ? {2'h0, b[7:6]} : b[7:4];
	endfunction : lane_bits

	function automatic logic [7:0] lane_shift(input logic [7:0] b, input logic [1:0] sh);
		lane_shift = (sh == SH_2) ? {b[5:0], 2'h0} : {b[3:0], 4'h0};
	endfunction : lane_shift

	// Frame sequencer: opcode, column, dummies, data stream
	always_comb begin
		state_next    = state_reg;
		cnt_next      = cnt_reg;
		dum_next      = dum_reg;
		op_next       = op_reg;
		sh_next       = sh_reg;
		col_next      = col_reg;
		addr_next     = addr_reg;
		in_sh_next    = in_sh_reg;
		out_sh_next   = out_sh_reg;
		buf_next      = buf_reg;
		io_next       = IO_O;
		oe_n_next     = IO_OE_N_O;
		page_adv_next = 1'b0;
		refused_next  = REFUSED_O;
		if (cs_n_s) begin
			// Deselect ends any frame and frees the lines
			state_next = ST_CMD;
			cnt_next   = '0;
			op_next    = '0;
			oe_n_next  = OE_OFF;
		end else begin
			unique case (state_reg)
				ST_CMD: begin
					if (sck_rise) begin
						op_next  = op_shift;
						cnt_next = cnt_reg + CNT_ONE;
						if (cnt_reg == OP_LAST) begin
							cnt_next     = '0;
							col_next     = '0;
							addr_next    = '0;
							buf_next     = BUF_MODE_I;
							refused_next = 1'b0;
							state_next   = ST_ADDR;
							in_sh_next   = SH_1;
							out_sh_next  = SH_2;
							// Single-line frames: dummy length by mode and framing
							dum_next     = BUF_MODE_I ? DUM_BUF : DUM_SEQ;
							case (op_next)
								OP_DOUT: ;
								OP_DOUT4: begin
									dum_next = BUF_MODE_I ? DUM4_BUF : DUM4_SEQ;
								end
								OP_QOUT: begin
									out_sh_next = SH_4;
								end
								OP_QOUT4: begin
									out_sh_next = SH_4;
									dum_next    = BUF_MODE_I ? DUM4_BUF : DUM4_SEQ;
								end
								OP_DIO, OP_DIO4: begin
									in_sh_next = SH_2;
									dum_next   = CNT_W'(DUMMY_DIO);
								end
								OP_QIO: begin
									in_sh_next  = SH_4;
									out_sh_next = SH_4;
									dum_next    = CNT_W'(DUMMY_QIO);
								end
								default: state_next = ST_IGNORE;
							endcase
							if (quad_op && WP_EN_I) begin
								// IO2/IO3 serve protect and hold here
								state_next   = ST_IGNORE;
								refused_next = 1'b1;
							end
						end
					end
				end
				ST_ADDR: begin
					if (sck_rise) begin
						// Highest line holds the highest column bit
						unique case (in_sh_reg)
							SH_1:    col_next = {col_reg[14:0], io_s[0]};
							SH_2:    col_next = {col_reg[13:0], io_s[1:0]};
							default: col_next = {col_reg[11:0], io_s[3:0]};
						endcase
						cnt_next = cnt_reg + CNT_ONE;
						if (cnt_reg == (COL_CLKS >> in_sh_reg) - CNT_ONE) begin
							cnt_next   = '0;
							state_next = ST_DUMMY;
						end
					end
				end
				ST_DUMMY: begin
					if (sck_rise) begin
						cnt_next = cnt_reg + CNT_ONE;
						if (cnt_reg == dum_reg - CNT_ONE) begin
							cnt_next   = '0;
							state_next = ST_DATA;
							// Sequential mode ignores the column entirely
							addr_next  = buf_reg ? col_reg : '0;
						end
					end
				end
				ST_DATA: begin
					if (sck_fall) begin
						if (cnt_reg == '0) begin
							if (buf_reg && (addr_reg > BUF_LAST)) begin
								// Past the last buffer byte: let the lines float
								state_next = ST_HALT;
								oe_n_next  = OE_OFF;
							end else begin
								io_next   = lane_bits(rd_byte, out_sh_reg);
								sh_next   = lane_shift(rd_byte, out_sh_reg);
								oe_n_next = (out_sh_reg == SH_2) ? OE_DUAL : OE_QUAD;
								cnt_next  = (BYTE_GRP >> out_sh_reg) - CNT_ONE;
								addr_next = addr_reg + ADDR_ONE;
								if (!buf_reg && (addr_reg == BUF_LAST)) begin
									// Array side must refill in time for a seamless stream
									addr_next     = '0;
									page_adv_next = 1'b1;
								end
							end
						end else begin
							io_next  = lane_bits(sh_reg, out_sh_reg);
							sh_next  = lane_shift(sh_reg, out_sh_reg);
							cnt_next = cnt_reg - CNT_ONE;
						end
					end
				end
				ST_HALT, ST_IGNORE: ;
			endcase
		end
	end

	// Registers of the sequencer, frozen while the clock enable is low
	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			state_reg  <= ST_CMD;
			cnt_reg    <= '0;
			dum_reg    <= '0;
			op_reg     <= '0;
			sh_reg     <= '0;
			col_reg    <= '0;
			addr_reg   <= '0;
			in_sh_reg  <= SH_1;
			out_sh_reg <= SH_2;
			buf_reg    <= 1'b0;
			sck_d_reg  <= 1'b0;
			IO_O       <= '0;
			IO_OE_N_O  <= OE_OFF;
			PAGE_ADV_O <= 1'b0;
			REFUSED_O  <= 1'b0;
		end else if (CE_I) begin
			state_reg  <= state_next;
			cnt_reg    <= cnt_next;
			dum_reg    <= dum_next;
			op_reg     <= op_next;
			sh_reg     <= sh_next;
			col_reg    <= col_next;
			addr_reg   <= addr_next;
			in_sh_reg  <= in_sh_next;
			out_sh_reg <= out_sh_next;
			buf_reg    <= buf_next;
			sck_d_reg  <= sck_s;
			IO_O       <= io_next;
			IO_OE_N_O  <= oe_n_next;
			PAGE_ADV_O <= page_adv_next;
			REFUSED_O  <= refused_next;
		end
	end

	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (RST_I);

	property p_halt_release;
		(state_reg == ST_HALT) |-> (IO_OE_N_O == OE_OFF);
	endproperty
	a_halt_release: assert property (p_halt_release) else $error("lines driven after buffer end");
	property p_wp_refuse;
		(CE_I && state_reg == ST_CMD && !cs_n_s && sck_rise && cnt_reg == OP_LAST && quad_op && WP_EN_I)
			|=> (state_reg == ST_IGNORE) && REFUSED_O ##1 (IO_OE_N_O == OE_OFF);
	endproperty
	a_wp_refuse: assert property (p_wp_refuse) else $error("quad read not refused");
	property p_dual_lanes;
		(state_reg == ST_DATA && out_sh_reg == SH_2 && IO_OE_N_O != OE_OFF) |-> (IO_OE_N_O == OE_DUAL);
	endproperty
	a_dual_lanes: assert property (p_dual_lanes) else $error("dual read drives wrong lines");
	property p_quad_lanes;
		(state_reg == ST_DATA && out_sh_reg == SH_4 && IO_OE_N_O != OE_OFF) |-> (IO_OE_N_O == OE_QUAD);
	endproperty
	a_quad_lanes: assert property (p_quad_lanes) else $error("quad read drives wrong lines");
	property p_seq_start;
		($rose(state_reg == ST_DATA) && !buf_reg) |-> (addr_reg == '0);
	endproperty
	a_seq_start: assert property (p_seq_start) else $error("sequential read not at byte zero");
	property p_buf_start;
		($rose(state_reg == ST_DATA) && buf_reg) |-> (addr_reg == col_reg);
	endproperty
	a_buf_start: assert property (p_buf_start) else $error("buffer read not at column");
	property p_page_adv;
		(PAGE_ADV_O && CE_I) |-> (addr_reg == '0) ##1 !PAGE_ADV_O;
	endproperty
	a_page_adv: assert property (p_page_adv) else $error("page advance wrong");
	property p_addr_step;
		(fetch_go && CE_I && !(buf_reg && addr_reg > BUF_LAST))
			|=> (addr_reg == $past(addr_reg) + ADDR_ONE) || (addr_reg == '0 && PAGE_ADV_O);
	endproperty
	a_addr_step: assert property (p_addr_step) else $error("address did not step by one");
	property p_msb_first;
		(fetch_go && CE_I && out_sh_reg == SH_4 && !(buf_reg && addr_reg > BUF_LAST)) |=> (IO_O == $past(rd_hi));
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("high nibble not first");
endmodule : mbr_read_path

// *** test/mbr_host_model.sv ***
`timescale 1ns/1ps
// Host controller in mode 0: SCK rests low and CS_N high between frames
module mbr_host_model (
	input  wire logic       clk_i,
	input  wire logic [3:0] io_o_i,
	input  wire logic [3:0] oe_n_i,
	output logic            sck_o,
	output logic            cs_n_o,
	output logic [3:0]      io_w_o
);
	logic [3:0] hv;
	logic [3:0] hen;
	logic [3:0] smp;
	logic [3:0] oe_s;
	logic       flip = 1'b0;
	logic [7:0] rx_q[$];
	logic [3:0] oe_q[$];

	// Idle levels at time zero
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		hv = 4'h0;
		hen = 4'h0;
	end

	// Released lines toggle off the sampling edge, so a stale level never passes for data
	always @(negedge clk_i) flip <= ~flip;

	// Wire level from both parties' enables
	assign io_w_o = (~oe_n_i & io_o_i) | (oe_n_i & hen & hv) | (oe_n_i & ~hen & {4{flip}});

	// One SCK period of 8 MCLK; device output is sampled just before the rise
	task automatic sck(input logic [3:0] v, input logic [3:0] en);
		hv = v;
		hen = en;
		repeat (4) @(negedge clk_i);
		smp = io_w_o;
		oe_s = oe_n_i;
		sck_o = 1'b1;
		repeat (4) @(negedge clk_i);
		sck_o = 1'b0;
	endtask : sck

	// Opcode on IO0, column on wa lines, nd dummies, nb bytes read on wd lines
	task automatic frame(input logic [7:0] op, input logic [15:0] col, input int wa, input int wd,
			input int nd, input int nb);
		logic [7:0]  b;
		logic [15:0] c;
		logic [3:0]  m;
		rx_q.delete();
		oe_q.delete();
		c = col;
		m = 4'((1 << wa) - 1);
		cs_n_o = 1'b0;
		for (int i = 7; i >= 0; i--) sck({3'h0, op[i]}, 4'h1);
		repeat (16 / wa) begin
			sck(4'(c >> (16 - wa)), m);
			c = c << wa;
		end
		repeat (nd) sck(4'h0, 4'h0);
		m = 4'((1 << wd) - 1);
		repeat (nb) begin
			repeat (8 / wd) begin
				sck(4'h0, 4'h0);
				b = (b << wd) | {4'h0, smp & m};
			end
			rx_q.push_back(b);
			oe_q.push_back(oe_s);
		end
		cs_n_o = 1'b1;
		repeat (8) @(negedge clk_i);
	endtask : frame
endmodule : mbr_host_model

// *** test/multi_io_buffer_read_path_tb_top.sv ***
`timescale 1ns/1ps
module multi_io_buffer_read_path_tb_top;
	import mbr_pkg::*;
	// Odd dummy counts so a swapped or fixed count shows up
	localparam int D_DIO = 3;
	localparam int D_QIO = 5;
	logic              MCLK_I, RST_I, CE_I, BUF_MODE_I, WP_EN_I, BUF_WE_I, SCK_I, CS_N_I, PAGE_ADV_O, REFUSED_O;
	logic [3:0]        IO_I, IO_O, IO_OE_N_O;
	logic [MEM_AW-1:0] BUF_WADDR_I;
	logic [7:0]        BUF_WDATA_I;
	int                err_total = 0;
	int                cmp_count = 0;
	int                adv_cnt = 0;

	mbr_read_path #(.DUMMY_DIO(D_DIO), .DUMMY_QIO(D_QIO)) i_dut (.MCLK_I(MCLK_I), .RST_I(RST_I), .CE_I(CE_I),
		.SCK_I(SCK_I), .CS_N_I(CS_N_I), .IO_I(IO_I), .IO_O(IO_O), .IO_OE_N_O(IO_OE_N_O), .BUF_MODE_I(BUF_MODE_I),
		.WP_EN_I(WP_EN_I), .BUF_WE_I(BUF_WE_I), .BUF_WADDR_I(BUF_WADDR_I), .BUF_WDATA_I(BUF_WDATA_I),
		.PAGE_ADV_O(PAGE_ADV_O), .REFUSED_O(REFUSED_O));
	mbr_host_model i_host (.clk_i(MCLK_I), .io_o_i(IO_O), .oe_n_i(IO_OE_N_O), .sck_o(SCK_I), .cs_n_o(CS_N_I),
		.io_w_o(IO_I));

	// 40 MHz system clock
	initial begin
		MCLK_I = 1'b0;
		forever #12.5 MCLK_I = ~MCLK_I;
	end

	// Page advance pulses are counted, not polled, since they last one cycle
	always @(posedge MCLK_I) if (PAGE_ADV_O === 1'b1) adv_cnt <= adv_cnt + 1;

	// Buffer content: low byte mixed with page bits so pages of the buffer differ
	function automatic logic [7:0] pat(input int a);
		return 8'(a) ^ 8'(a >> 8) ^ 8'h5a;
	endfunction : pat

	task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %0t %s", $time, m);
		end
	endtask : chk

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : summarize

	// Back-to-back buffer writes
	task automatic load();
		for (int a = 0; a < BUF_BYTES; a++) begin
			BUF_WE_I = 1'b1;
			BUF_WADDR_I = MEM_AW'(a);
			BUF_WDATA_I = pat(a);
			@(negedge MCLK_I);
		end
		BUF_WE_I = 1'b0;
	endtask : load

	// Every opcode in buffer mode, then two in sequential mode with a column that must be ignored
	task automatic t_modes();
		logic [7:0] ops[9] = '{OP_DOUT, OP_DOUT4, OP_QOUT, OP_QOUT4, OP_DIO, OP_DIO4, OP_QIO, OP_DOUT4, OP_DIO};
		int         wa[9] = '{1, 1, 1, 1, 2, 2, 4, 1, 2};
		int         wd[9] = '{2, 2, 4, 4, 2, 2, 4, 2, 2};
		int         nd[9] = '{8, 24, 8, 24, D_DIO, D_DIO, D_QIO, 40, D_DIO};
		int         s;
		for (int k = 0; k < 9; k++) begin
			BUF_MODE_I = (k < 7);
			s = (k < 7) ? 16'h0123 + 37 * k : 0;
			i_host.frame(ops[k], 16'(16'h0123 + 37 * k), wa[k], wd[k], nd[k], 3);
			for (int j = 0; j < 3; j++) begin
				chk(i_host.rx_q[j], pat(s + j), "data");
				chk({4'h0, i_host.oe_q[j]}, {4'h0, wd[k] == 4 ? OE_QUAD : OE_DUAL}, "lanes");
			end
		end
	endtask : t_modes

	// Column at the second last byte: two bytes, then lines released
	task automatic t_end();
		BUF_MODE_I = 1'b1;
		i_host.frame(OP_QOUT, BUF_LAST - ADDR_ONE, 1, 4, 8, 4);
		chk(i_host.rx_q[0], pat(BUF_BYTES - 2), "tail");
		chk(i_host.rx_q[1], pat(BUF_BYTES - 1), "last");
		chk({4'h0, i_host.oe_q[2]}, {4'h0, OE_OFF}, "release");
		chk({4'h0, i_host.oe_q[3]}, {4'h0, OE_OFF}, "stays released");
	endtask : t_end

	// Whole buffer plus two bytes in sequential mode
	task automatic t_seq();
		int a0;
		BUF_MODE_I = 1'b0;
		a0 = adv_cnt;
		i_host.frame(OP_QOUT, 16'h0040, 1, 4, 32, BUF_BYTES + 2);
		for (int j = 0; j < BUF_BYTES + 2; j++) chk(i_host.rx_q[j], pat(j % BUF_BYTES), "seq");
		chk(8'(adv_cnt - a0), 8'h01, "page advance");
	endtask : t_seq

	// Quad reads refused under protect, dual still served
	task automatic t_wp();
		logic [7:0] ops[3] = '{OP_QOUT, OP_QOUT4, OP_QIO};
		int         wa[3] = '{1, 1, 4};
		int         nd[3] = '{8, 24, D_QIO};
		WP_EN_I = 1'b1;
		BUF_MODE_I = 1'b1;
		for (int k = 0; k < 3; k++) begin
			i_host.frame(ops[k], 16'h0010, wa[k], 4, nd[k], 2);
			chk({4'h0, i_host.oe_q[0] & i_host.oe_q[1]}, {4'h0, OE_OFF}, "quad refused");
			chk({7'h0, REFUSED_O}, 8'h01, "refused flag");
		end
		// Clock enable low: a whole frame goes unseen and the flag holds
		CE_I = 1'b0;
		i_host.frame(OP_DOUT, 16'h0010, 1, 2, 8, 1);
		chk({4'h0, i_host.oe_q[0]}, {4'h0, OE_OFF}, "frozen lines");
		chk({7'h0, REFUSED_O}, 8'h01, "frozen flag");
		CE_I = 1'b1;
		i_host.frame(OP_DOUT, 16'h0010, 1, 2, 8, 1);
		chk(i_host.rx_q[0], pat(16), "dual allowed");
		chk({7'h0, REFUSED_O}, 8'h00, "flag cleared");
		WP_EN_I = 1'b0;
	endtask : t_wp

	// Main sequence
	initial begin
		RST_I = 1'b1;
		CE_I = 1'b1;
		BUF_MODE_I = 1'b1;
		WP_EN_I = 1'b0;
		BUF_WE_I = 1'b0;
		BUF_WADDR_I = '0;
		BUF_WDATA_I = 8'h00;
		repeat (2) @(negedge MCLK_I);
		RST_I = 1'b0;
		chk({4'h0, IO_OE_N_O}, {4'h0, OE_OFF}, "idle lines");
		load();
		t_modes();
		t_end();
		t_seq();
		t_wp();
		summarize();
	end

	// Watchdog: the tests need about 43000 cycles
	initial begin
		repeat (80000) @(posedge MCLK_I);
		err_total++;
		summarize();
	end
endmodule : multi_io_buffer_read_path_tb_top
